// ### asrc_pkg.sv
// Shared constants and types of the converter control and its host.
package asrc_pkg;
  // ==========================================================
  // Clock and data widths
  localparam int REF_PERIOD_NS = 100;
  localparam int DATA_W = 14;
  localparam int CHANS = 4;
  localparam int CNT_W = 5;
  // ==========================================================
  // Conversion timing, in ns, kHz, reference cycles or converter ticks
  localparam int INT_CONV_NS = 1650;
  localparam int INT_CONV_CYC = (INT_CONV_NS + REF_PERIOD_NS - 1) /
                                REF_PERIOD_NS;
  localparam int EXT_CONV_TICKS = 16;
  localparam int EXT_RESULT_TICK = 14;
  localparam int EOC_LOW_TICKS = 2;
  localparam int EXT_CLK_MAX_KHZ = 5000;
  localparam int EXT_HALF_CYC = (1000000 / REF_PERIOD_NS +
                                 2 * EXT_CLK_MAX_KHZ - 1) /
                                (2 * EXT_CLK_MAX_KHZ);
  // ==========================================================
  // Host bus timing
  localparam int QUIET_NS = 100;
  localparam int QUIET_CYC = (QUIET_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int GAP_CYC = QUIET_CYC + 1;
  localparam int STROBE_LOW_CYC = 2;
  localparam int WAKE_NS = 2000;
  localparam int WAKE_CYC = (WAKE_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int LONG_STANDBY_N_MS = 1;
  localparam int LONG_WAKE_MS = 6;
  localparam int TMR_W = 16;
  // ==========================================================
  // Host register map and fields
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CHSEL = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_DATA = 8'h0C;
  localparam logic [7:0] REG_CMD = 8'h10;
  localparam int CTRL_HWSW_BIT = 0;
  localparam int CTRL_STBYN_BIT = 1;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_READ_BIT = 1;
  localparam int CMD_WRITE_BIT = 2;
  localparam int DATA_FIRST_BIT = 16;
  localparam logic [1:0] CTRL_RESET = 2'h2;
  localparam logic [3:0] CHSEL_RESET = 4'hF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // State types
  typedef enum logic [0:0] {SEQ_IDLE, SEQ_CONV} asrc_seq_e;
  typedef enum logic [2:0] {H_IDLE, H_START, H_WRITE, H_READ, H_GAP}
    asrc_host_e;
endpackage : asrc_pkg

// ### asrc_link_if.sv
// Parallel link between the converter control and its host.
`timescale 1ns/1ns
`default_nettype none
interface asrc_link_if;
  import asrc_pkg::*;
  logic convStartN;
  logic csN;
  logic rdN;
  logic wrN;
  logic [DATA_W-1:0] hostData;
  logic hostDataOe;
  logic [DATA_W-1:0] devData;
  logic devDataOe;
  logic [DATA_W-1:0] dataBus;
  logic busy;
  logic eocN;
  logic firstFlag;
  logic [CHANS-1:0] chanPins;
  logic hwSwSelect;
  logic standbyN;
  logic extClk;
  // ==========================================================
  // Bus level: the device wins, then the host; an undriven bus shows the
  // inverse of the device's last word so a stale value cannot pass.
  assign dataBus = devDataOe ? devData : (hostDataOe ? hostData : ~devData);
  modport dev (input convStartN, csN, rdN, wrN, dataBus, chanPins,
    hwSwSelect, standbyN, extClk, output devData, devDataOe, busy, eocN,
    firstFlag);
  modport host (output convStartN, csN, rdN, wrN, hostData, hostDataOe,
    chanPins, hwSwSelect, standbyN, extClk, input dataBus, busy, eocN,
    firstFlag);
endinterface : asrc_link_if
`default_nettype wire

// ### asrc_device.sv
// Converter end: sequencing, result registers, pointer and bus drive.
// ==========================================================
// Summary of operation
// (RQ1) Start rising edge holds all four samples.
// (RQ2) Internal clock: results every 1.65 us; here every 17 reference cycles, 1.7 us.
// (RQ3) End-of-conversion falls per finished channel.
// (RQ4) Busy high until all selected channels done.
// (RQ5) Drive bus only when select and read low.
// (RQ6) Result stored as end-of-conversion falls.
// (RQ7) Host should read while end-of-conversion low.
// (RQ8) Host leaves quiet time before next start.
// (RQ9) First result resets pointer, raises first flag.
// (RQ10) Read advances pointer only if next exists.
// (RQ11) Reads during conversion repeat current register.
// (RQ12) Reading last result wraps pointer to first.
// (RQ13) After busy, each read advances; flag drops.
// (RQ14) First flag level undefined after power-up.
// (RQ15) Host keeps minimum spacing between reads.
// (RQ16) Select high: external clock, at most 5 MHz.
// (RQ17) External clock: sixteen clocks per conversion.
// (RQ18) Tick fourteen of first: pointer, flag, result.
// (RQ19) Tick fourteen of second clears first flag; here only if a read left a pending pointer advance or lands on that same tick.
// (RQ20) External: end-of-conversion low at tick fourteen.
// (RQ21) Standby input idles converter; results stay readable.
// (RQ22) Host waits wake-up time after standby.
// (RQ23) Selected subset converted in ascending order.
// (RQ24) Software channel enables latched on write rise.
`timescale 1ns/1ns
`default_nettype none
module asrc_device
  import asrc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  asrc_link_if.dev link,
  input wire logic [CHANS-1:0][DATA_W-1:0] analogIn,
  output logic lowPower
);
  // ==========================================================
  // Helpers for channel order.
  function automatic logic [1:0] lowestIdx(input logic [CHANS-1:0] m);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = CHANS - 1; i >= 0; i--) begin
      if (m[i]) begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction : lowestIdx

  function automatic logic [2:0] countOnes(input logic [CHANS-1:0] m);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < CHANS; i++) begin
      n = n + 3'(m[i]);
    end
    return n;
  endfunction : countOnes

  asrc_seq_e state_reg;
  logic startPrev_reg, rdPrev_reg, wrPrev_reg, extPrev_reg;
  logic extSeq_reg, busy_reg, eocN_reg, pend_reg, pend_next;
  logic firstFlag_reg;
  logic [CHANS-1:0] swSel_reg, mask_reg;
  logic [1:0] chan_reg, ptr_reg, ptr_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [1:0] eocHold_reg;
  logic [2:0] doneCnt_reg, numSel_reg;
  logic [CHANS-1:0][DATA_W-1:0] held_reg;
  logic [DATA_W-1:0] mem [CHANS];
  logic [DATA_W-1:0] dataOut_reg;

  // ==========================================================
  // Edge detection on the link strobes.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      startPrev_reg <= 1'b1;
      rdPrev_reg <= 1'b1;
      wrPrev_reg <= 1'b1;
      extPrev_reg <= 1'b0;
    end else begin
      startPrev_reg <= link.convStartN;
      rdPrev_reg <= link.rdN;
      wrPrev_reg <= link.wrN;
      extPrev_reg <= link.extClk;
    end
  end

  logic startEv, rdEv, wrEv, tick, startOk, resEv, endEv;
  logic [CHANS-1:0] selCur, maskLeft;
  logic [CNT_W-1:0] cntInc, resTick, convLen;
  logic [2:0] doneEff;
  assign startEv = !startPrev_reg && link.convStartN; // RQ1
  assign rdEv = !rdPrev_reg && link.rdN && !link.csN;
  assign wrEv = !wrPrev_reg && link.wrN && !link.csN && link.rdN; // RQ24
  // Software selection goes with the external clock, pins otherwise.
  assign selCur = link.hwSwSelect ? swSel_reg : link.chanPins;
  // Starts are refused while converting, in standby or with no channel.
  assign startOk = startEv && state_reg == SEQ_IDLE && link.standbyN &&
                   selCur != '0; // RQ21
  // External mode steps on falling clock edges; internal every cycle.
  assign tick = extSeq_reg ? (extPrev_reg && !link.extClk) : 1'b1; // RQ16
  assign resTick = extSeq_reg ? CNT_W'(EXT_RESULT_TICK) :
                   CNT_W'(INT_CONV_CYC); // RQ2 RQ20
  assign convLen = extSeq_reg ? CNT_W'(EXT_CONV_TICKS) :
                   CNT_W'(INT_CONV_CYC); // RQ17
  assign cntInc = CNT_W'(cnt_reg + 1'b1);
  assign resEv = state_reg == SEQ_CONV && tick && cntInc == resTick;
  assign endEv = state_reg == SEQ_CONV && tick && cntInc == convLen;
  assign maskLeft = mask_reg & ~(CHANS'(1) << chan_reg);
  assign doneEff = doneCnt_reg + 3'(resEv);

  // ==========================================================
  // Software channel register.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      swSel_reg <= '0;
    end else if (wrEv) begin
      swSel_reg <= link.dataBus[CHANS-1:0]; // RQ24
    end
  end

  // ==========================================================
  // Sequencer: one channel at a time, lowest selected first.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= SEQ_IDLE;
      busy_reg <= 1'b0;
      extSeq_reg <= 1'b0;
      mask_reg <= '0;
      chan_reg <= 2'h0;
      cnt_reg <= '0;
      numSel_reg <= 3'h0;
    end else if (startOk) begin
      state_reg <= SEQ_CONV;
      busy_reg <= 1'b1; // RQ4
      extSeq_reg <= link.hwSwSelect; // RQ16
      mask_reg <= selCur;
      chan_reg <= lowestIdx(selCur); // RQ23
      cnt_reg <= '0;
      numSel_reg <= countOnes(selCur);
    end else if (endEv) begin
      cnt_reg <= '0;
      mask_reg <= maskLeft;
      chan_reg <= lowestIdx(maskLeft); // RQ23
      if (maskLeft == '0) begin
        state_reg <= SEQ_IDLE;
        busy_reg <= 1'b0; // RQ4
      end
    end else if (tick && state_reg == SEQ_CONV) begin
      cnt_reg <= cntInc;
    end
  end

  // ==========================================================
  // Track/hold: all channels frozen together at the start edge.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      held_reg <= '0;
    end else if (startOk) begin
      held_reg <= analogIn; // RQ1
    end
  end

  // ==========================================================
  // Result registers, filled in conversion order. No reset is needed.
  always_ff @(posedge ref_clk) begin
    if (resEv) begin
      mem[doneCnt_reg[1:0]] <= held_reg[chan_reg]; // RQ6 RQ18
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      doneCnt_reg <= 3'h0;
    end else if (startOk) begin
      doneCnt_reg <= 3'h0;
    end else if (resEv) begin
      doneCnt_reg <= doneEff;
    end
  end

  // ==========================================================
  // End-of-conversion: low with the result, high a few ticks later.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      eocN_reg <= 1'b1;
      eocHold_reg <= 2'h0;
    end else if (resEv) begin
      eocN_reg <= 1'b0; // RQ3 RQ20
      eocHold_reg <= 2'(EOC_LOW_TICKS);
    end else if (tick && !eocN_reg) begin
      eocHold_reg <= eocHold_reg - 2'h1;
      if (eocHold_reg == 2'h1) begin
        eocN_reg <= 1'b1; // RQ20
      end
    end
  end

  // ==========================================================
  // Pointer. A read that finds no next result leaves a pending
  // advance, taken when that result lands.
  always_comb begin
    ptr_next = ptr_reg;
    pend_next = pend_reg;
    if (startOk) begin
      pend_next = 1'b0;
    end else if (resEv && doneCnt_reg == 3'h0) begin
      ptr_next = 2'h0; // RQ9 RQ18
      pend_next = 1'b0;
    end else if (rdEv) begin
      if (doneEff == numSel_reg &&
          {1'b0, ptr_reg} == numSel_reg - 3'h1) begin
        ptr_next = 2'h0; // RQ12
      end else if ({1'b0, ptr_reg} + 3'h1 < doneEff) begin
        ptr_next = ptr_reg + 2'h1; // RQ10 RQ13
      end else begin
        pend_next = 1'b1; // RQ11
      end
    end else if (resEv && pend_reg &&
                 doneCnt_reg == {1'b0, ptr_reg} + 3'h1) begin
      ptr_next = ptr_reg + 2'h1; // RQ10
      pend_next = 1'b0;
    end
  end

  // The flag simply mirrors a pointer at the first register.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ptr_reg <= 2'h0;
      pend_reg <= 1'b0;
      firstFlag_reg <= 1'b1; // RQ14
    end else begin
      ptr_reg <= ptr_next;
      pend_reg <= pend_next;
      firstFlag_reg <= ptr_next == 2'h0; // RQ9 RQ13 RQ19
    end
  end

  // ==========================================================
  // Read data lags the pointer by one cycle, so hosts hold read low
  // for at least two cycles.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dataOut_reg <= '0;
      lowPower <= 1'b0;
    end else begin
      dataOut_reg <= mem[ptr_reg]; // RQ11
      lowPower <= !link.standbyN && !busy_reg; // RQ21
    end
  end

  assign link.devData = dataOut_reg;
  assign link.devDataOe = !link.csN && !link.rdN; // RQ5 RQ21
  assign link.busy = busy_reg;
  assign link.eocN = eocN_reg;
  assign link.firstFlag = firstFlag_reg;
endmodule : asrc_device
`default_nettype wire

// ### asrc_host.sv
// Host end: AXI4-Lite registers driving the converter's parallel link.
`timescale 1ns/1ns
`default_nettype none
module asrc_host
  import asrc_pkg::*;
#(
  parameter int LONG_STANDBY_N_CYC = LONG_STANDBY_N_MS * 1000000 / REF_PERIOD_NS,
  parameter int LONG_WAKE_CYC = LONG_WAKE_MS * 1000000 / REF_PERIOD_NS
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  asrc_link_if.host link
);
  asrc_host_e state_reg;
  logic awHave_reg, wHave_reg, doWrite, readTaken;
  logic [ADDR_W-1:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic [1:0] ctrl_reg;
  logic [CHANS-1:0] chsel_reg;
  logic [2:0] req_reg, taken;
  logic [DATA_W-1:0] rdData_reg;
  logic rdFirst_reg, extClk_reg, startN_reg, csN_reg, rdN_reg, wrN_reg;
  logic oe_reg;
  logic [TMR_W-1:0] tmr_reg, wake_reg, sby_reg, div_reg;

  // ==========================================================
  // Write channel: address and data in either order, then response.
  assign awready = !awHave_reg;
  assign wready = !wHave_reg;
  assign doWrite = awHave_reg && wHave_reg && !bvalid;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      awHave_reg <= 1'b0;
      wHave_reg <= 1'b0;
      awAddr_reg <= '0;
      wData_reg <= '0;
      wStrb_reg <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHave_reg <= 1'b1;
        awAddr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        wHave_reg <= 1'b1;
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
      end
      if (doWrite) begin
        awHave_reg <= 1'b0;
        wHave_reg <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (awAddr_reg == REG_CTRL || awAddr_reg == REG_CHSEL ||
                  awAddr_reg == REG_CMD) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Control registers; command bits stay set until the link takes them,
  // and a new set wins over a take in the same cycle.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= CTRL_RESET;
      chsel_reg <= CHSEL_RESET;
      req_reg <= '0;
    end else begin
      req_reg <= (req_reg & ~taken) |
                 ((doWrite && awAddr_reg == REG_CMD && wStrb_reg[0]) ?
                  wData_reg[2:0] : 3'h0);
      if (doWrite && wStrb_reg[0] && awAddr_reg == REG_CTRL) begin
        ctrl_reg <= wData_reg[1:0];
      end
      if (doWrite && wStrb_reg[0] && awAddr_reg == REG_CHSEL) begin
        chsel_reg <= wData_reg[CHANS-1:0];
      end
    end
  end

  // ==========================================================
  // Read channel: one-cycle answer, unmapped addresses report error.
  assign arready = !rvalid;
  assign readTaken = arvalid && arready;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (readTaken) begin
      rvalid <= 1'b1;
      rresp <= RESP_OKAY;
      unique case (araddr)
        REG_CTRL: rdata <= 32'(ctrl_reg);
        REG_CHSEL: rdata <= 32'(chsel_reg);
        REG_STATUS: rdata <= 32'({wake_reg != '0,
                                  (state_reg != H_IDLE || req_reg != '0),
                                  link.firstFlag, link.eocN, link.busy});
        REG_DATA: rdata <= 32'({rdFirst_reg, 2'h0, rdData_reg});
        REG_CMD: rdata <= 32'(req_reg);
        default: begin
          rdata <= '0;
          rresp <= RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Standby length and wake-up wait; once standby is released a start waits for the wake timer.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sby_reg <= '0;
      wake_reg <= '0;
    end else if (!ctrl_reg[CTRL_STBYN_BIT]) begin
      if (sby_reg < TMR_W'(LONG_STANDBY_N_CYC)) begin
        sby_reg <= sby_reg + 1'b1;
      end
      wake_reg <= (sby_reg < TMR_W'(LONG_STANDBY_N_CYC)) ? TMR_W'(WAKE_CYC) :
                  TMR_W'(LONG_WAKE_CYC); // RQ22
    end else begin
      sby_reg <= '0;
      if (wake_reg != '0) begin
        wake_reg <= wake_reg - 1'b1;
      end
    end
  end

  // ==========================================================
  // External conversion clock, divided down to at most 5 MHz.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_reg <= '0;
      extClk_reg <= 1'b0;
    end else if (div_reg == TMR_W'(EXT_HALF_CYC - 1)) begin
      div_reg <= '0;
      extClk_reg <= ctrl_reg[CTRL_HWSW_BIT] && !extClk_reg; // RQ16
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // ==========================================================
  // Link sequencer: write, read, then start, each followed by a gap.
  always_comb begin
    taken = 3'h0;
    if (state_reg == H_IDLE) begin
      if (req_reg[CMD_WRITE_BIT]) begin
        taken[CMD_WRITE_BIT] = 1'b1;
      end else if (req_reg[CMD_READ_BIT]) begin
        taken[CMD_READ_BIT] = 1'b1;
      // In standby a start goes out at once and the converter refuses it;
      // the wake-up wait only holds a start back once standby is released.
      end else if (req_reg[CMD_START_BIT] &&
                   (wake_reg == '0 || !ctrl_reg[CTRL_STBYN_BIT])) begin
        taken[CMD_START_BIT] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= H_IDLE;
      tmr_reg <= '0;
      startN_reg <= 1'b1;
      csN_reg <= 1'b1;
      rdN_reg <= 1'b1;
      wrN_reg <= 1'b1;
      oe_reg <= 1'b0;
      rdData_reg <= '0;
      rdFirst_reg <= 1'b0;
    end else begin
      tmr_reg <= tmr_reg - 1'b1;
      unique case (state_reg)
        H_IDLE: begin
          tmr_reg <= TMR_W'(STROBE_LOW_CYC);
          if (taken[CMD_WRITE_BIT]) begin
            state_reg <= H_WRITE;
            csN_reg <= 1'b0;
            wrN_reg <= 1'b0;
            oe_reg <= 1'b1; // RQ24
          end else if (taken[CMD_READ_BIT]) begin
            state_reg <= H_READ;
            csN_reg <= 1'b0;
            rdN_reg <= 1'b0;
          end else if (taken[CMD_START_BIT]) begin
            state_reg <= H_START;
            startN_reg <= 1'b0;
          end
        end
        H_START: begin
          startN_reg <= 1'b1;
          state_reg <= H_GAP;
          tmr_reg <= TMR_W'(GAP_CYC);
        end
        H_WRITE, H_READ: begin
          if (tmr_reg == TMR_W'(1)) begin
            if (state_reg == H_READ) begin
              rdData_reg <= link.dataBus;
              rdFirst_reg <= link.firstFlag;
            end
            rdN_reg <= 1'b1;
            wrN_reg <= 1'b1;
            state_reg <= H_GAP;
            tmr_reg <= TMR_W'(GAP_CYC); // RQ8 RQ15
          end
        end
        H_GAP: begin
          // Select outlives the strobe by a cycle, so the converter sees
          // the strobe rise while it is still selected.
          csN_reg <= 1'b1;
          oe_reg <= 1'b0;
          if (tmr_reg == TMR_W'(1)) begin
            state_reg <= H_IDLE;
          end
        end
      endcase
    end
  end

  assign link.convStartN = startN_reg;
  assign link.csN = csN_reg;
  assign link.rdN = rdN_reg;
  assign link.wrN = wrN_reg;
  assign link.hostData = oe_reg ? DATA_W'(chsel_reg) : '0;
  assign link.hostDataOe = oe_reg;
  assign link.chanPins = chsel_reg;
  assign link.hwSwSelect = ctrl_reg[CTRL_HWSW_BIT];
  assign link.standbyN = ctrl_reg[CTRL_STBYN_BIT];
  assign link.extClk = extClk_reg;
endmodule : asrc_host
`default_nettype wire

// ### asrc_sva.sv
// Checker of the parallel link between converter and host.
`timescale 1ns/1ns
`default_nettype none
module asrc_sva
  import asrc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic convStartN,
  input wire logic csN,
  input wire logic rdN,
  input wire logic devDataOe,
  input wire logic busy,
  input wire logic eocN,
  input wire logic firstFlag,
  input wire logic [CHANS-1:0] chanPins,
  input wire logic hwSwSelect,
  input wire logic standbyN
);
  // ==========================================================
  // Clocking
  // One clock domain, so every check sleeps while reset is held.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // An awake, idle device sees a start with pins selecting channels.
  sequence startTaken;
    $rose(convStartN) && !busy && standbyN && !hwSwSelect && |chanPins;
  endsequence
  // The first internal result lands seventeen ticks after busy rises.
  sequence firstInt;
    $rose(busy) && !hwSwSelect ##17 $fell(eocN);
  endsequence
  // ==========================================================
  // Checks
  // The drive window is gated by select and read alone.
  oe_gate_a: assert property (devDataOe == (!csN && !rdN))
    else $error("bus drive outside read");
  start_busy_a: assert property (startTaken |=> busy)
    else $error("start not taken");
  first_time_a: assert property (
    $rose(busy) && !hwSwSelect |-> ##17 $fell(eocN))
    else $error("first result late or early");
  first_flag_a: assert property (firstInt |-> firstFlag)
    else $error("first flag low at first result");
  int_pulse_a: assert property (
    $fell(eocN) && !hwSwSelect |-> ##1 !eocN ##1 eocN)
    else $error("end pulse width wrong");
  ext_pulse_a: assert property (
    $fell(eocN) && hwSwSelect |-> !eocN[*4] ##1 eocN)
    else $error("external end pulse wrong");
  busy_end_a: assert property (
    $fell(busy) |-> $fell(eocN) || $rose(eocN))
    else $error("busy fell off a result");
  standby_n_refuse_a: assert property (
    $rose(convStartN) && !standbyN && !busy |=> !busy ##1 !busy)
    else $error("start taken in standby");
endmodule : asrc_sva
`default_nettype wire

// ### adc_sequence_readout_control_tb.sv
// Bench: host and converter joined, driven over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module adc_sequence_readout_control_tb
  import asrc_pkg::*;
;
  logic ref_clk = 0, resetn = 0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, lowPower;
  logic [31:0] wdata = '0, rdata, d, want;
  logic [1:0] bresp, rresp, r;
  logic [CHANS-1:0][DATA_W-1:0] analogIn = '0;
  int errors = 0, numChecks = 0;
  int ch[3] = '{0, 1, 3};
  asrc_link_if link();
  asrc_device asrc_device_inst (.ref_clk, .resetn, .link, .analogIn,
    .lowPower);
  asrc_host asrc_host_inst (.ref_clk, .resetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .link);
  asrc_sva asrc_sva_inst (.ref_clk, .resetn,
    .convStartN(link.convStartN), .csN(link.csN), .rdN(link.rdN),
    .devDataOe(link.devDataOe), .busy(link.busy), .eocN(link.eocN),
    .firstFlag(link.firstFlag), .chanPins(link.chanPins),
    .hwSwSelect(link.hwSwSelect), .standbyN(link.standbyN));
  // ==========================================================
  // Clock and hang guard
  // Clock at the reference rate.
  initial forever #(REF_PERIOD_NS / 2) ref_clk = ~ref_clk;
  // A stuck handshake ends the run as a failure.
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    summarize();
  end
  // ==========================================================
  // Bus tasks
  // Each half is released once taken; one idle edge avoids a re-raise clash.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    r = bresp;
    bready <= 0;
    @(posedge ref_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 0;
    @(posedge ref_clk);
  endtask : rd
  task automatic chk(input string n, input logic [31:0] s, e);
    numChecks++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask : chk
  // Poll status until the masked bits are all clear.
  task automatic poll(input logic [31:0] m);
    do rd(REG_STATUS); while ((d & m) !== '0);
  endtask : poll
  function automatic logic [13:0] smp(int k, int m);
    return 14'(14'h0111 * (k + 1) + 14'h1000 * m);
  endfunction : smp
  task automatic summarize();
    $display("checks %0d errors %0d", numChecks, errors);
    if (errors == 0 && numChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  // ==========================================================
  // Tests
  // Internal then external clock, three channels, four reads each after busy falls.
  initial begin
    repeat (10) @(posedge ref_clk);
    resetn <= 1;
    @(posedge ref_clk);
    rd(8'h14);
    chk("bad rd", {30'h0, r}, 32'(RESP_SLVERR));
    wr(REG_STATUS, '0);
    chk("bad wr", {30'h0, r}, 32'(RESP_SLVERR));
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 4; k++) analogIn[k] <= smp(k, m);
      wr(REG_CTRL, 32'(2 + m));
      wr(REG_CHSEL, 32'h0000_000B);
      wr(REG_CMD, 32'h0000_0005);
      // External run: read once after the first result's end pulse falls,
      // before the second result lands, so the pointer waits for that result before it moves on.
      if (m == 1) begin
        poll(32'h0000_0002);
        wr(REG_CMD, 32'h0000_0002);
        poll(32'h0000_0008);
        rd(REG_DATA);
        chk("mid data", d, {15'h0, 1'b1, 2'h0, smp(0, 1)});
      end
      poll(32'h0000_0019);
      chk("first flag", {31'h0, d[2]}, 32'(m == 0));
      for (int i = 0; i < 4; i++) begin
        wr(REG_CMD, 32'h0000_0002);
        poll(32'h0000_0008);
        rd(REG_DATA);
        want = {15'h0, (i + m) % 3 == 0, 2'h0, smp(ch[(i + m) % 3], m)};
        chk("data", d, want);
      end
    end
    // Standby refuses a start yet results stay readable.
    wr(REG_CTRL, '0);
    wr(REG_CMD, 32'h0000_0001);
    poll(32'h0000_0008);
    chk("busy", {31'h0, link.busy}, '0);
    chk("low power", {31'h0, lowPower}, 32'h0000_0001);
    wr(REG_CMD, 32'h0000_0002);
    poll(32'h0000_0008);
    rd(REG_DATA);
    chk("standby_n data", d, {18'h0, smp(3, 1)});
    summarize();
  end
endmodule : adc_sequence_readout_control_tb
`default_nettype wire
